/* core/bvp_map.vh */
`ifndef BVP_MAP_VH
`define BVP_MAP_VH

// Register byte offsets
`define BVP_OFS_CTRL      8'h00
`define BVP_OFS_COV_THR   8'h04
`define BVP_OFS_COV_REC   8'h08
`define BVP_OFS_COV_TIME  8'h0C
`define BVP_OFS_POV_THR   8'h10
`define BVP_OFS_POV_REC   8'h14
`define BVP_OFS_POV_TIME  8'h18
`define BVP_OFS_CUV_THR   8'h1C
`define BVP_OFS_CUV_REC   8'h20
`define BVP_OFS_CUV_TIME  8'h24
`define BVP_OFS_OT_CHG    8'h28
`define BVP_OFS_COV_HYS   8'h2C
`define BVP_OFS_COV_DELTA 8'h30
`define BVP_OFS_DSG_CUR   8'h34
`define BVP_OFS_CHG_CUR   8'h38
`define BVP_OFS_ALERT     8'h3C
`define BVP_OFS_SAFETY    8'h40
`define BVP_OFS_BATT      8'h44
`define BVP_OFS_INT_STAT  8'h48
`define BVP_OFS_INT_MASK  8'h4C

// Reset values
`define BVP_RST_CTRL      2'h1
`define BVP_RST_COV_THR   16'h10CC
`define BVP_RST_COV_REC   16'h0F3C
`define BVP_RST_COV_TIME  8'h02
`define BVP_RST_POV_THR   16'h445C
`define BVP_RST_POV_REC   16'h3E80
`define BVP_RST_POV_TIME  8'h02
`define BVP_RST_CUV_THR   16'h0898
`define BVP_RST_CUV_REC   16'h0BB8
`define BVP_RST_CUV_TIME  8'h02
`define BVP_RST_OT_CHG    16'h0226
`define BVP_RST_COV_HYS   8'h64
`define BVP_RST_COV_DELTA 8'h14
`define BVP_RST_DSG_CUR   16'h0064
`define BVP_RST_CHG_CUR   16'h0064
`define BVP_RST_INT_MASK  6'h00

// Pre-charge mode value that routes the pre-charge FET
`define BVP_PRECHG_SEL    2'h1

// Field positions: alert, safety status
`define BVP_B_COV         0
`define BVP_B_POV         1
`define BVP_B_CUV         2
// Battery status word
`define BVP_B_TCA         0
`define BVP_B_TDA         1
`define BVP_B_FD          2
`define BVP_B_DISCHARGE_BLOCKED_FLAG        3
// Interrupt events
`define BVP_I_COV_TRIP    0
`define BVP_I_POV_TRIP    1
`define BVP_I_CUV_TRIP    2
`define BVP_I_COV_REC     3
`define BVP_I_POV_REC     4
`define BVP_I_CUV_REC     5

// Qualification timer width, in bits
`define BVP_TIME_W        8

`endif

/* core/bvp_qual_timer.v */
`timescale 1ns/1ps
`default_nettype none
`include "bvp_map.vh"

module bvp_qual_timer (
	// Clock and reset
	input  wire                   clk_i,
	input  wire                   rst_i,
	// Qualification
	input  wire                   cond_i,
	input  wire                   tick_i,
	input  wire [`BVP_TIME_W-1:0] limit_i,
	// Result
	output wire                   pending_o,
	output wire                   expire_o
);

	reg  [`BVP_TIME_W-1:0] cnt_r;
	wire [`BVP_TIME_W-1:0] cnt_inc;
	wire                   run;

	// Zero limit disables the check entirely
	assign run       = cond_i & (limit_i != {`BVP_TIME_W{1'b0}});
	assign cnt_inc   = cnt_r + {{(`BVP_TIME_W-1){1'b0}}, 1'b1};
	assign pending_o = run;
	assign expire_o  = run & tick_i & (cnt_inc >= limit_i); // [R18]

	// First tick after onset may be a partial second; accepted for a one-second base
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_r <= {`BVP_TIME_W{1'b0}};
		end else if (!run || expire_o) begin
			cnt_r <= {`BVP_TIME_W{1'b0}}; // [R18]
		end else if (tick_i) begin
			cnt_r <= cnt_inc; // [R18]
		end
	end

endmodule // bvp_qual_timer

`default_nettype wire

/* core/bvp_top.v */
// Contract
// [R01] Cell overvoltage qualified turns charge FET off
// [R02] Cell overvoltage alert while qualification pending
// [R03] Cell overvoltage trip: FETs, requests, alarm, status
// [R04] Cell overvoltage recovery when all cells low
// [R05] Cell overvoltage: charge FET on while discharging
// [R06] Hot charging lowers cell overvoltage threshold
// [R07] Zero delta disables threshold compensation
// [R08] Pack overvoltage qualified turns charge FET off
// [R09] Pack overvoltage alert while qualification pending
// [R10] Pack overvoltage trip: FETs, requests, alarm, status
// [R11] Pack overvoltage recovery at recovery threshold
// [R12] Pack overvoltage: charge FET on while discharging
// [R13] Cell undervoltage qualified turns discharge FET off
// [R14] Cell undervoltage alert while qualification pending
// [R15] Cell undervoltage trip: FETs, alarms, pre-charge
// [R16] Cell undervoltage recovery when all cells high
// [R17] Cell undervoltage: discharge FET on while charging
// [R18] Timers count seconds, restart on onset
`timescale 1ns/1ps
`default_nettype none
`include "bvp_map.vh"

module bvp_top (
	// Clock and reset
	input  wire        CORE_CLK_I,
	input  wire        RST_I,
	// Register port
	input  wire [7:0]  REG_ADDR_I,
	input  wire [31:0] REG_WDATA_I,
	input  wire        REG_WR_I,
	input  wire        REG_RD_I,
	output wire [31:0] REG_RDATA_O,
	// Measurements
	input  wire        SEC_TICK_I,
	input  wire [15:0] CELL1_MV_I,
	input  wire [15:0] CELL2_MV_I,
	input  wire [15:0] CELL3_MV_I,
	input  wire [15:0] CELL4_MV_I,
	input  wire [15:0] PACK_MV_I,
	input  wire [15:0] CURRENT_MA_I,
	input  wire [15:0] TEMP_DC_I,
	input  wire        DISCHARGING_I,
	// FET controls
	output wire        CHG_FET_O,
	output wire        DSG_FET_O,
	output wire        PRECHARGE_FET_O,
	// Status words
	output wire [2:0]  SAFETY_ALERT_O,
	output wire [2:0]  SAFETY_STATUS_O,
	output wire        CHARGE_STOP_ALARM_O,
	output wire        DISCHARGE_STOP_ALARM_O,
	output wire        FULLY_DISCHARGED_FLAG_O,
	output wire        DISCHARGE_BLOCKED_FLAG_O,
	output wire        CHG_REQ_ZERO_O,
	output wire        CHG_REQ_PRECHARGE_O,
	// Interrupt
	output wire        IRQ_O
);

	// Stored configuration
	reg  [1:0]             precharge_mode_r;
	reg  [15:0]            cov_thr_r;
	reg  [15:0]            cov_rec_r;
	reg  [`BVP_TIME_W-1:0] cov_time_r;
	reg  [15:0]            pov_thr_r;
	reg  [15:0]            pov_rec_r;
	reg  [`BVP_TIME_W-1:0] pov_time_r;
	reg  [15:0]            cuv_thr_r;
	reg  [15:0]            cuv_rec_r;
	reg  [`BVP_TIME_W-1:0] cuv_time_r;
	reg  [15:0]            ot_chg_r;
	reg  [7:0]             cov_hys_r;
	reg  [7:0]             cov_delta_r;
	reg  [15:0]            dsg_cur_r;
	reg  [15:0]            chg_cur_r;
	reg  [5:0]             int_mask_r;

	// Protection state
	reg  [2:0]             alert_r;
	reg  [2:0]             status_r;
	reg  [2:0]             status_nxt;
	reg                    tda_r;
	reg                    tda_nxt;
	reg                    fd_r;
	reg                    fd_nxt;
	reg                    discharge_blocked_flag_r;
	reg                    discharge_blocked_flag_nxt;
	reg                    chg_fet_r;
	reg                    dsg_fet_r;
	reg                    pre_fet_r;
	reg                    req_zero_r;
	reg                    req_pre_r;
	reg  [5:0]             int_stat_r;
	reg  [5:0]             int_stat_nxt;
	reg                    irq_r;
	reg  [31:0]            rdata_r;
	reg  [31:0]            rdata_nxt;

	// Comparisons
	wire [15:0]            cell_mv [0:3];
	wire [3:0]             cell_ov;
	wire [3:0]             cell_ov_ok;
	wire [3:0]             cell_uv;
	wire [3:0]             cell_uv_ok;
	wire [16:0]            cov_thr_comp;
	wire [15:0]            cov_thr_eff;
	wire signed [16:0]     temp_s;
	wire signed [16:0]     hot_lim_s;
	wire                   comp_on;
	wire                   cov_cond;
	wire                   pov_cond;
	wire                   cuv_cond;
	wire                   cov_recov;
	wire                   pov_recov;
	wire                   cuv_recov;
	wire                   cov_pend;
	wire                   pov_pend;
	wire                   cuv_pend;
	wire                   cov_trip;
	wire                   pov_trip;
	wire                   cuv_trip;
	wire [2:0]             recov_ev;
	wire signed [16:0]     cur_s;
	wire signed [16:0]     dsg_lim_s;
	wire signed [16:0]     chg_lim_s;
	wire                   body_dsg;
	wire                   body_chg;
	wire                   ov_state;
	wire                   pre_sel;
	wire                   rd_int;
	wire [5:0]             events;

	assign cell_mv[0] = CELL1_MV_I;
	assign cell_mv[1] = CELL2_MV_I;
	assign cell_mv[2] = CELL3_MV_I;
	assign cell_mv[3] = CELL4_MV_I;

	// Threshold compensation while charging and hot
	assign temp_s       = $signed({1'b0, TEMP_DC_I});
	assign hot_lim_s    = $signed({1'b0, ot_chg_r}) - $signed({9'h000, cov_hys_r});
	assign comp_on      = !DISCHARGING_I && (temp_s > hot_lim_s) // [R06]
	                      && (cov_delta_r != 8'h00); // [R07]
	assign cov_thr_comp = {1'b0, cov_thr_r} - {9'h000, cov_delta_r};
	// Clamp at zero so an oversized delta cannot wrap to a huge threshold
	assign cov_thr_eff  = !comp_on ? cov_thr_r :
	                      (cov_thr_comp[16] ? 16'h0000 : cov_thr_comp[15:0]); // [R06]

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_cell
			assign cell_ov[gi]    = cell_mv[gi] >= cov_thr_eff; // [R01]
			assign cell_ov_ok[gi] = cell_mv[gi] <= cov_rec_r; // [R04]
			assign cell_uv[gi]    = cell_mv[gi] <= cuv_thr_r; // [R13]
			assign cell_uv_ok[gi] = cell_mv[gi] >= cuv_rec_r; // [R16]
		end
	endgenerate

	assign cov_cond  = (|cell_ov) && !status_r[`BVP_B_COV];
	assign pov_cond  = (PACK_MV_I >= pov_thr_r) && !status_r[`BVP_B_POV]; // [R08]
	assign cuv_cond  = (|cell_uv) && !status_r[`BVP_B_CUV];
	assign cov_recov = (&cell_ov_ok) && status_r[`BVP_B_COV]; // [R04]
	assign pov_recov = (PACK_MV_I <= pov_rec_r) && status_r[`BVP_B_POV]; // [R11]
	assign cuv_recov = (&cell_uv_ok) && status_r[`BVP_B_CUV]; // [R16]
	assign recov_ev  = {cuv_recov, pov_recov, cov_recov};

	bvp_qual_timer u_cov_tmr (
		.clk_i     (CORE_CLK_I),
		.rst_i     (RST_I),
		.cond_i    (cov_cond),
		.tick_i    (SEC_TICK_I),
		.limit_i   (cov_time_r),
		.pending_o (cov_pend),
		.expire_o  (cov_trip)
	);

	bvp_qual_timer u_pov_tmr (
		.clk_i     (CORE_CLK_I),
		.rst_i     (RST_I),
		.cond_i    (pov_cond),
		.tick_i    (SEC_TICK_I),
		.limit_i   (pov_time_r),
		.pending_o (pov_pend),
		.expire_o  (pov_trip)
	);

	bvp_qual_timer u_cuv_tmr (
		.clk_i     (CORE_CLK_I),
		.rst_i     (RST_I),
		.cond_i    (cuv_cond),
		.tick_i    (SEC_TICK_I),
		.limit_i   (cuv_time_r),
		.pending_o (cuv_pend),
		.expire_o  (cuv_trip)
	);

	// Body-diode protection current windows
	assign cur_s     = $signed({CURRENT_MA_I[15], CURRENT_MA_I});
	assign dsg_lim_s = -$signed({1'b0, dsg_cur_r});
	assign chg_lim_s = $signed({1'b0, chg_cur_r});
	assign body_dsg  = cur_s <= dsg_lim_s; // [R05] [R12]
	assign body_chg  = cur_s >= chg_lim_s; // [R17]

	// Status flags; trip and recovery are exclusive because a timer idles while tripped
	always @* begin
		status_nxt = status_r;
		if (cov_trip)
			status_nxt[`BVP_B_COV] = 1'b1; // [R03]
		else if (cov_recov)
			status_nxt[`BVP_B_COV] = 1'b0; // [R04]
		if (pov_trip)
			status_nxt[`BVP_B_POV] = 1'b1; // [R10]
		else if (pov_recov)
			status_nxt[`BVP_B_POV] = 1'b0; // [R11]
		if (cuv_trip)
			status_nxt[`BVP_B_CUV] = 1'b1; // [R15]
		else if (cuv_recov)
			status_nxt[`BVP_B_CUV] = 1'b0; // [R16]
	end

	// Discharge-side flags; the fully-discharged flag is left for software to clear
	always @* begin
		tda_nxt  = tda_r;
		fd_nxt   = fd_r;
		discharge_blocked_flag_nxt = discharge_blocked_flag_r;
		if (REG_WR_I && REG_ADDR_I == `BVP_OFS_BATT && REG_WDATA_I[`BVP_B_FD])
			fd_nxt = 1'b0;
		if (cuv_recov) begin
			tda_nxt  = 1'b0; // [R16]
			discharge_blocked_flag_nxt = 1'b0; // [R16]
		end
		if (cuv_trip) begin
			tda_nxt  = 1'b1; // [R15]
			fd_nxt   = 1'b1; // [R15]
			discharge_blocked_flag_nxt = 1'b1; // [R15]
		end
	end

	assign ov_state = status_nxt[`BVP_B_COV] | status_nxt[`BVP_B_POV];
	assign pre_sel  = precharge_mode_r == `BVP_PRECHG_SEL;

	// Interrupt events: trips and full recoveries; a set beats a read clear
	assign events = {recov_ev, cuv_trip, pov_trip, cov_trip};
	assign rd_int = REG_RD_I && (REG_ADDR_I == `BVP_OFS_INT_STAT);
	always @* begin
		int_stat_nxt = (rd_int ? 6'h00 : int_stat_r) | events;
	end

	// Read mux; data stand only in the cycle after the strobe
	always @* begin
		rdata_nxt = 32'h0000_0000;
		if (REG_RD_I) begin
			case (REG_ADDR_I)
				`BVP_OFS_CTRL:      rdata_nxt = {30'h0, precharge_mode_r};
				`BVP_OFS_COV_THR:   rdata_nxt = {16'h0, cov_thr_r};
				`BVP_OFS_COV_REC:   rdata_nxt = {16'h0, cov_rec_r};
				`BVP_OFS_COV_TIME:  rdata_nxt = {24'h0, cov_time_r};
				`BVP_OFS_POV_THR:   rdata_nxt = {16'h0, pov_thr_r};
				`BVP_OFS_POV_REC:   rdata_nxt = {16'h0, pov_rec_r};
				`BVP_OFS_POV_TIME:  rdata_nxt = {24'h0, pov_time_r};
				`BVP_OFS_CUV_THR:   rdata_nxt = {16'h0, cuv_thr_r};
				`BVP_OFS_CUV_REC:   rdata_nxt = {16'h0, cuv_rec_r};
				`BVP_OFS_CUV_TIME:  rdata_nxt = {24'h0, cuv_time_r};
				`BVP_OFS_OT_CHG:    rdata_nxt = {16'h0, ot_chg_r};
				`BVP_OFS_COV_HYS:   rdata_nxt = {24'h0, cov_hys_r};
				`BVP_OFS_COV_DELTA: rdata_nxt = {24'h0, cov_delta_r};
				`BVP_OFS_DSG_CUR:   rdata_nxt = {16'h0, dsg_cur_r};
				`BVP_OFS_CHG_CUR:   rdata_nxt = {16'h0, chg_cur_r};
				`BVP_OFS_ALERT:     rdata_nxt = {29'h0, alert_r};
				`BVP_OFS_SAFETY:    rdata_nxt = {29'h0, status_r};
				`BVP_OFS_BATT:      rdata_nxt = {28'h0, discharge_blocked_flag_r, fd_r, tda_r, req_zero_r};
				`BVP_OFS_INT_STAT:  rdata_nxt = {26'h0, int_stat_r};
				`BVP_OFS_INT_MASK:  rdata_nxt = {26'h0, int_mask_r};
				default:            rdata_nxt = 32'h0000_0000;
			endcase
		end
	end

	// Configuration writes
	always @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			precharge_mode_r <= `BVP_RST_CTRL;
			cov_thr_r        <= `BVP_RST_COV_THR;
			cov_rec_r        <= `BVP_RST_COV_REC;
			cov_time_r       <= `BVP_RST_COV_TIME;
			pov_thr_r        <= `BVP_RST_POV_THR;
			pov_rec_r        <= `BVP_RST_POV_REC;
			pov_time_r       <= `BVP_RST_POV_TIME;
			cuv_thr_r        <= `BVP_RST_CUV_THR;
			cuv_rec_r        <= `BVP_RST_CUV_REC;
			cuv_time_r       <= `BVP_RST_CUV_TIME;
			ot_chg_r         <= `BVP_RST_OT_CHG;
			cov_hys_r        <= `BVP_RST_COV_HYS;
			cov_delta_r      <= `BVP_RST_COV_DELTA;
			dsg_cur_r        <= `BVP_RST_DSG_CUR;
			chg_cur_r        <= `BVP_RST_CHG_CUR;
			int_mask_r       <= `BVP_RST_INT_MASK;
		end else if (REG_WR_I) begin
			case (REG_ADDR_I)
				`BVP_OFS_CTRL:      precharge_mode_r <= REG_WDATA_I[1:0];
				`BVP_OFS_COV_THR:   cov_thr_r        <= REG_WDATA_I[15:0];
				`BVP_OFS_COV_REC:   cov_rec_r        <= REG_WDATA_I[15:0];
				`BVP_OFS_COV_TIME:  cov_time_r       <= REG_WDATA_I[7:0];
				`BVP_OFS_POV_THR:   pov_thr_r        <= REG_WDATA_I[15:0];
				`BVP_OFS_POV_REC:   pov_rec_r        <= REG_WDATA_I[15:0];
				`BVP_OFS_POV_TIME:  pov_time_r       <= REG_WDATA_I[7:0];
				`BVP_OFS_CUV_THR:   cuv_thr_r        <= REG_WDATA_I[15:0];
				`BVP_OFS_CUV_REC:   cuv_rec_r        <= REG_WDATA_I[15:0];
				`BVP_OFS_CUV_TIME:  cuv_time_r       <= REG_WDATA_I[7:0];
				`BVP_OFS_OT_CHG:    ot_chg_r         <= REG_WDATA_I[15:0];
				`BVP_OFS_COV_HYS:   cov_hys_r        <= REG_WDATA_I[7:0];
				`BVP_OFS_COV_DELTA: cov_delta_r      <= REG_WDATA_I[7:0];
				`BVP_OFS_DSG_CUR:   dsg_cur_r        <= REG_WDATA_I[15:0];
				`BVP_OFS_CHG_CUR:   chg_cur_r        <= REG_WDATA_I[15:0];
				`BVP_OFS_INT_MASK:  int_mask_r       <= REG_WDATA_I[5:0];
				default:            int_mask_r       <= int_mask_r;
			endcase
		end
	end

	// Protection outputs, all registered
	always @(posedge CORE_CLK_I or posedge RST_I) begin
		if (RST_I) begin
			alert_r    <= 3'h0;
			status_r   <= 3'h0;
			tda_r      <= 1'b0;
			fd_r       <= 1'b0;
			discharge_blocked_flag_r     <= 1'b0;
			chg_fet_r  <= 1'b0;
			dsg_fet_r  <= 1'b0;
			pre_fet_r  <= 1'b0;
			req_zero_r <= 1'b0;
			req_pre_r  <= 1'b0;
			int_stat_r <= 6'h00;
			irq_r      <= 1'b0;
			rdata_r    <= 32'h0000_0000;
		end else begin
			alert_r[`BVP_B_COV] <= cov_pend & !cov_trip; // [R02]
			alert_r[`BVP_B_POV] <= pov_pend & !pov_trip; // [R09]
			alert_r[`BVP_B_CUV] <= cuv_pend & !cuv_trip; // [R14]
			status_r   <= status_nxt;
			tda_r      <= tda_nxt;
			fd_r       <= fd_nxt;
			discharge_blocked_flag_r     <= discharge_blocked_flag_nxt;
			// Charge FET off in any overvoltage state unless discharge current reaches dsg_cur_r
			chg_fet_r  <= !ov_state | body_dsg; // [R01] [R03] [R05] [R08] [R10] [R12]
			dsg_fet_r  <= !status_nxt[`BVP_B_CUV] | body_chg; // [R13] [R15] [R17]
			// Overvoltage wins: no pre-charge path while charge must stop
			pre_fet_r  <= pre_sel & status_nxt[`BVP_B_CUV] & !ov_state; // [R03] [R10] [R15]
			req_zero_r <= ov_state; // [R03] [R04] [R10] [R11]
			req_pre_r  <= status_nxt[`BVP_B_CUV] & !ov_state; // [R15] [R16]
			int_stat_r <= int_stat_nxt;
			irq_r      <= |(int_stat_nxt & int_mask_r);
			rdata_r    <= rdata_nxt;
		end
	end

	assign REG_RDATA_O              = rdata_r;
	assign CHG_FET_O                = chg_fet_r;
	assign DSG_FET_O                = dsg_fet_r;
	assign PRECHARGE_FET_O          = pre_fet_r;
	assign SAFETY_ALERT_O           = alert_r;
	assign SAFETY_STATUS_O          = status_r;
	assign CHARGE_STOP_ALARM_O      = req_zero_r;
	assign DISCHARGE_STOP_ALARM_O   = tda_r;
	assign FULLY_DISCHARGED_FLAG_O  = fd_r;
	assign DISCHARGE_BLOCKED_FLAG_O = discharge_blocked_flag_r;
	assign CHG_REQ_ZERO_O           = req_zero_r;
	assign CHG_REQ_PRECHARGE_O      = req_pre_r;
	assign IRQ_O                    = irq_r;

endmodule // bvp_top

`default_nettype wire

/* verification/bvp_props.sv */
`timescale 1ns/1ps
`default_nettype none
`include "bvp_map.vh"

module bvp_props (
	// Clock and reset
	input wire logic        CORE_CLK_I,
	input wire logic        RST_I,
	// Register port
	input wire logic        REG_RD_I,
	input wire logic [31:0] REG_RDATA_O,
	// Measurements
	input wire logic        SEC_TICK_I,
	input wire logic [15:0] CELL1_MV_I,
	input wire logic [15:0] CELL2_MV_I,
	input wire logic [15:0] CELL3_MV_I,
	input wire logic [15:0] CELL4_MV_I,
	input wire logic [15:0] PACK_MV_I,
	input wire logic [15:0] CURRENT_MA_I,
	// Watched outputs
	input wire logic        CHG_FET_O,
	input wire logic        DSG_FET_O,
	input wire logic [2:0]  SAFETY_ALERT_O,
	input wire logic [2:0]  SAFETY_STATUS_O,
	input wire logic        CHARGE_STOP_ALARM_O,
	input wire logic        DISCHARGE_STOP_ALARM_O,
	input wire logic        FULLY_DISCHARGED_FLAG_O,
	input wire logic        DISCHARGE_BLOCKED_FLAG_O,
	input wire logic        CHG_REQ_ZERO_O
);
	// Thresholds are taken at reset values: the bench never rewrites them
	localparam int DSG_THR = `BVP_RST_DSG_CUR;
	localparam int CHG_THR = `BVP_RST_CHG_CUR;
	wire logic signed [15:0] cur_s = CURRENT_MA_I;
	wire logic ov_any = |SAFETY_STATUS_O[1:0];
	wire logic cells_low = CELL1_MV_I <= `BVP_RST_COV_REC && CELL2_MV_I <= `BVP_RST_COV_REC
		&& CELL3_MV_I <= `BVP_RST_COV_REC && CELL4_MV_I <= `BVP_RST_COV_REC;
	wire logic cells_high = CELL1_MV_I >= `BVP_RST_CUV_REC && CELL2_MV_I >= `BVP_RST_CUV_REC
		&& CELL3_MV_I >= `BVP_RST_CUV_REC && CELL4_MV_I >= `BVP_RST_CUV_REC;

	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (RST_I);

	rdata_idle_a: assert property (!$past(REG_RD_I) |-> REG_RDATA_O == 32'h0)
		else $error("read data not zero outside answer cycle");
	alarm_req_a: assert property (
		CHARGE_STOP_ALARM_O == ov_any && CHG_REQ_ZERO_O == ov_any)
		else $error("charge alarm or request out of step with status");
	alert_excl_a: assert property ((SAFETY_ALERT_O & SAFETY_STATUS_O) == 3'h0)
		else $error("alert still set beside tripped status");
	trip_tick_a: assert property (
		|(SAFETY_STATUS_O & ~$past(SAFETY_STATUS_O)) |-> $past(SEC_TICK_I))
		else $error("trip without a seconds tick");
	cuv_trip_a: assert property ($rose(SAFETY_STATUS_O[2]) |->
		DISCHARGE_STOP_ALARM_O && FULLY_DISCHARGED_FLAG_O && DISCHARGE_BLOCKED_FLAG_O)
		else $error("undervoltage trip flags missing");
	cuv_rec_a: assert property ($fell(SAFETY_STATUS_O[2]) |->
		$past(cells_high) && !DISCHARGE_STOP_ALARM_O && !DISCHARGE_BLOCKED_FLAG_O)
		else $error("undervoltage recovery wrong");
	cov_rec_a: assert property ($fell(SAFETY_STATUS_O[0]) |-> $past(cells_low))
		else $error("cell overvoltage recovered too early");
	pov_rec_a: assert property (
		$fell(SAFETY_STATUS_O[1]) |-> $past(PACK_MV_I) <= `BVP_RST_POV_REC)
		else $error("pack overvoltage recovered too early");
	chg_diode_a: assert property (ov_any && $past(ov_any) |->
		CHG_FET_O == ($past(cur_s) <= -DSG_THR))
		else $error("charge FET wrong while overvoltage status set");
	dsg_diode_a: assert property (SAFETY_STATUS_O[2] && $past(SAFETY_STATUS_O[2]) |->
		DSG_FET_O == ($past(cur_s) >= CHG_THR))
		else $error("discharge FET wrong while undervoltage status set");
	chg_free_a: assert property (!ov_any && !$past(ov_any) && !$past(RST_I) |-> CHG_FET_O)
		else $error("charge FET off without a fault");
	dsg_free_a: assert property (
		!SAFETY_STATUS_O[2] && !$past(SAFETY_STATUS_O[2]) && !$past(RST_I) |-> DSG_FET_O)
		else $error("discharge FET off without a fault");
endmodule // bvp_props

bind bvp_top bvp_props u_props (
	.CORE_CLK_I, .RST_I, .REG_RD_I, .REG_RDATA_O, .SEC_TICK_I,
	.CELL1_MV_I, .CELL2_MV_I, .CELL3_MV_I, .CELL4_MV_I, .PACK_MV_I, .CURRENT_MA_I,
	.CHG_FET_O, .DSG_FET_O, .SAFETY_ALERT_O, .SAFETY_STATUS_O, .CHARGE_STOP_ALARM_O,
	.DISCHARGE_STOP_ALARM_O, .FULLY_DISCHARGED_FLAG_O, .DISCHARGE_BLOCKED_FLAG_O,
	.CHG_REQ_ZERO_O
);
`default_nettype wire

/* verification/bvp_fet_drv.sv */
`timescale 1ns/1ps
`default_nettype none

// Gates follow their enables one clock late, like a level shifter
module bvp_fet_drv (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Enables {pre-charge, discharge, charge}
	input  wire logic [2:0] en_i,
	// Gate states
	output var  logic [2:0] gate_o
);
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			gate_o <= 3'h0;
		end else begin
			gate_o <= en_i;
		end
	end
endmodule // bvp_fet_drv
`default_nettype wire

/* verification/battery_voltage_protection_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "bvp_map.vh"

module battery_voltage_protection_tb;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        tick = 1'b0;
	logic [15:0] c1 = 16'h0DAC, c2 = 16'h0DAC, c3 = 16'h0DAC, c4 = 16'h0DAC;
	logic [15:0] pack = 16'h36B0;
	logic [15:0] cur = 16'h0000;
	logic [15:0] temp = 16'h00FA;
	logic        dis = 1'b0;
	wire  [31:0] rdata;
	wire         chg, dsgf, pre, tca, discharge_stop_alarm, fd, discharge_blocked_flag, rz, rp, irq;
	wire  [2:0]  alert, stat, gate;
	wire  [14:0] obs = {alert, stat, tca, discharge_stop_alarm, fd, discharge_blocked_flag, rz, rp, gate};
	integer      seed = 32'h29FD;
	integer      fails = 0, cmp_count = 0, cyc = 0, i;
	logic [31:0] rv [0:14] = '{`BVP_RST_CTRL, `BVP_RST_COV_THR, `BVP_RST_COV_REC,
		`BVP_RST_COV_TIME, `BVP_RST_POV_THR, `BVP_RST_POV_REC, `BVP_RST_POV_TIME,
		`BVP_RST_CUV_THR, `BVP_RST_CUV_REC, `BVP_RST_CUV_TIME, `BVP_RST_OT_CHG,
		`BVP_RST_COV_HYS, `BVP_RST_COV_DELTA, `BVP_RST_DSG_CUR, `BVP_RST_CHG_CUR};
	logic [15:0] cc [0:5] = '{16'h10B8, 16'h10B8, 16'h10B8, 16'h10B7, 16'h10B8, 16'h10CC};
	logic [15:0] tt [0:5] = '{16'h01C3, 16'h01C2, 16'h01C3, 16'h01C3, 16'h01C3, 16'h01C3};
	logic [5:0]  dd = 6'h04;

	bvp_top u_dut (
		.CORE_CLK_I(clk), .RST_I(rst), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
		.REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .SEC_TICK_I(tick),
		.CELL1_MV_I(c1), .CELL2_MV_I(c2), .CELL3_MV_I(c3), .CELL4_MV_I(c4),
		.PACK_MV_I(pack), .CURRENT_MA_I(cur), .TEMP_DC_I(temp), .DISCHARGING_I(dis),
		.CHG_FET_O(chg), .DSG_FET_O(dsgf), .PRECHARGE_FET_O(pre),
		.SAFETY_ALERT_O(alert), .SAFETY_STATUS_O(stat), .CHARGE_STOP_ALARM_O(tca),
		.DISCHARGE_STOP_ALARM_O(discharge_stop_alarm), .FULLY_DISCHARGED_FLAG_O(fd),
		.DISCHARGE_BLOCKED_FLAG_O(discharge_blocked_flag), .CHG_REQ_ZERO_O(rz),
		.CHG_REQ_PRECHARGE_O(rp), .IRQ_O(irq)
	);
	bvp_fet_drv u_fet (.clk_i(clk), .rst_i(rst), .en_i({pre, dsgf, chg}), .gate_o(gate));

	initial begin
		forever #4 clk = ~clk;
	end

	task automatic tally_and_finish;
		if (fails == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// Run is a few hundred cycles; the ceiling only catches a hang
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 32'h4E20) begin
			fails = fails + 1;
			tally_and_finish;
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count = cmp_count + 1;
		if (seen !== exp) begin
			fails = fails + 1;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// Expected alert: effective threshold lowered only when charging, hot and delta nonzero
	function automatic logic cov_exp(input logic [15:0] c, input logic [15:0] t,
		input logic d, input logic [7:0] dl);
		cov_exp = c >= ((!d && dl != 8'h00 && t > `BVP_RST_OT_CHG - `BVP_RST_COV_HYS) ?
			`BVP_RST_COV_THR - dl : `BVP_RST_COV_THR);
	endfunction

	task automatic w(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, e);
	endtask

	// Cell 1 carries the test value; the others wander inside the safe band
	task automatic drive(input logic [15:0] c, input logic [15:0] p);
		@(posedge clk);
		c1 <= c;
		c2 <= 16'h0C1C + 16'({$random(seed)} % 32'h2BC);
		c3 <= 16'h0C1C + 16'({$random(seed)} % 32'h2BC);
		c4 <= 16'h0C1C + 16'({$random(seed)} % 32'h2BC);
		pack <= (p != 16'h0) ? p : 16'h2EE0 + 16'({$random(seed)} % 32'hFA0);
	endtask

	task automatic ticks(input int n);
		repeat (n) begin
			@(posedge clk);
			tick <= 1'b1;
			@(posedge clk);
			tick <= 1'b0;
			repeat (3) @(posedge clk);
		end
		#1;
	endtask

	task automatic set_cur(input logic [15:0] v);
		@(posedge clk);
		cur <= v;
		w(3);
	endtask

	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		w(2);
		for (i = 0; i < 20; i = i + 1) begin
			rd_chk(8'(4 * i), i < 15 ? rv[i] : 32'h0);
		end
		rd_chk(8'h80, 32'h0);
		// Cell overvoltage right at the threshold
		drive(16'h10CC, 16'h0);
		w(2);
		chk(obs, {3'h1, 3'h0, 6'h00, 3'h3});
		ticks(1);
		chk(obs, {3'h1, 3'h0, 6'h00, 3'h3});
		drive(16'h10CB, 16'h0);
		w(2);
		chk(alert, 3'h0);
		ticks(1);
		drive(16'h10CC, 16'h0);
		ticks(1);
		chk(stat, 3'h0);
		ticks(1);
		chk(obs, {3'h0, 3'h1, 6'h22, 3'h2});
		chk(irq, 1'b0);
		wr_reg(`BVP_OFS_INT_MASK, 32'h3F);
		w(2);
		chk(irq, 1'b1);
		wr_reg(`BVP_OFS_SAFETY, 32'h0);
		rd_chk(`BVP_OFS_SAFETY, 32'h1);
		rd_chk(`BVP_OFS_INT_STAT, 32'h1);
		w(2);
		chk(irq, 1'b0);
		set_cur(16'hFF9C);
		chk(obs, {3'h0, 3'h1, 6'h22, 3'h3});
		set_cur(16'hFF9D);
		chk(gate, 3'h2);
		drive(16'h0F3D, 16'h0);
		w(3);
		chk(stat, 3'h1);
		drive(16'h0F3C, 16'h0);
		w(3);
		chk(obs, {3'h0, 3'h0, 6'h00, 3'h3});
		rd_chk(`BVP_OFS_INT_STAT, 32'h8);
		// Hot charging lowers the threshold; a zero delta turns that off
		for (i = 0; i < 6; i = i + 1) begin
			if (i == 4) wr_reg(`BVP_OFS_COV_DELTA, 32'h0);
			@(posedge clk);
			temp <= tt[i];
			dis <= dd[i];
			drive(cc[i], 16'h0);
			w(2);
			chk(alert[0], cov_exp(cc[i], tt[i], dd[i], i < 4 ? `BVP_RST_COV_DELTA : 8'h00));
			drive(16'h0DAC, 16'h0);
			w(2);
		end
		// Pack overvoltage: zero time first, then a real trip
		wr_reg(`BVP_OFS_POV_TIME, 32'h0);
		drive(16'h0DAC, 16'h445C);
		ticks(3);
		chk({alert, stat}, 6'h00);
		drive(16'h0DAC, 16'h0);
		wr_reg(`BVP_OFS_POV_TIME, 32'h2);
		drive(16'h0DAC, 16'h445B);
		w(2);
		chk(alert, 3'h0);
		drive(16'h0DAC, 16'h445C);
		w(2);
		chk(alert, 3'h2);
		ticks(2);
		chk(obs, {3'h0, 3'h2, 6'h22, 3'h2});
		set_cur(16'hFF9C);
		chk(obs, {3'h0, 3'h2, 6'h22, 3'h3});
		set_cur(16'hFF9D);
		drive(16'h0DAC, 16'h3E81);
		w(3);
		chk(stat, 3'h2);
		drive(16'h0DAC, 16'h3E80);
		w(3);
		chk(obs, {3'h0, 3'h0, 6'h00, 3'h3});
		rd_chk(`BVP_OFS_INT_STAT, 32'h12);
		// Cell undervoltage with the pre-charge path selected
		drive(16'h0898, 16'h0);
		w(2);
		chk(alert, 3'h4);
		ticks(2);
		chk(obs, {3'h0, 3'h4, 6'h1D, 3'h5});
		rd_chk(`BVP_OFS_BATT, 32'hE);
		set_cur(16'h0064);
		chk(obs, {3'h0, 3'h4, 6'h1D, 3'h7});
		set_cur(16'h0063);
		chk(gate, 3'h5);
		drive(16'h0BB7, 16'h0);
		w(3);
		chk(stat, 3'h4);
		drive(16'h0BB8, 16'h0);
		w(3);
		chk(obs, {3'h0, 3'h0, 6'h08, 3'h3});
		rd_chk(`BVP_OFS_INT_STAT, 32'h24);
		wr_reg(`BVP_OFS_BATT, 32'h4);
		rd_chk(`BVP_OFS_BATT, 32'h0);
		// Pre-charge path not selected: its FET stays off
		wr_reg(`BVP_OFS_CTRL, 32'h2);
		drive(16'h0898, 16'h0);
		ticks(2);
		chk({stat, gate}, {3'h4, 3'h1});
		drive(16'h0BB8, 16'h0);
		w(3);
		chk(gate, 3'h3);
		tally_and_finish;
	end
endmodule // battery_voltage_protection_tb
`default_nettype wire
